// ---- rtl/hbc_ctrl.sv ----
// h-bridge step-up/step-down switching-state controller with axi4-lite registers
//
// Overview of operation
// - shutdown or tiny charge setting stops switching and grounds compensation nodes
// - during inhibit other than lockout, regulator, current monitor and logic stay alive
// - pick states A, B, C from voltages; idle D at light load
// - vin above 1.4 vbatt: alternate A and B, low side off
// - state A turns high side off, state B turns it on
// - step-down: high side stays on in B until on-time timer ends
// - step-down: each B expiry starts a new A off-time
// - error follows limited charge or source current, else battery voltage
// - vin below 0.9 vbatt: alternate B and C, high side on
// - state C turns low side on; current crossing target returns to B
// - step-up: low side stays off in B until off-time timer ends
// - between 0.9 and 1.4: order A, B, C, B, A
// - combined mode: C ends on peak, A on valley, rest in B
// - error below 0.15V: discontinuous, no new step-down on-time
// - discontinuous step-up: minimum current threshold ends state C
// - current comparator ends A below threshold, C above threshold
// - current limit ends step-up on-time and blocks step-down on-time
// - limit uses charge sense in step-down, source sense in step-up
// - zero crossing during step-down off-time goes to idle D
// - B time from voltages and time constant, doubled in combined mode; here a fixed count from the btime register, not from voltages
// - state choice and timing driven by five comparator outputs
// - only one power switch toggles at each switching transition, except that an inhibit in state C turns both off together
// - adapter below lockout threshold enters low-power shutdown
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "hbc_defines.svh"

module hbc_ctrl
  import hbc_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // comparators and monitors
  input  wire hbc_cmp_s    cmp,
  input  wire hbc_mon_s    mon,
  // power stage and loop outputs
  output var  logic        high_side_gate_drive,
  output var  logic        low_side_gate_drive,
  output var  logic        comp_nodes_clamp,
  output var  logic        internal_regulator,
  output var  hbc_err_e    error_select,
  output var  logic        limit_sense_source,
  // axi4-lite write
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  hbc_st_s r;
  hbc_st_s n;
  logic    inhibit;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic [15:0] bload;
    logic        b_done;
    logic [31:0] cur;
    logic [31:0] rd;
    logic        wr_ok;
    bload  = 16'h0000;
    b_done = 1'b0;
    cur    = 32'h0000_0000;
    rd     = 32'h0000_0000;
    wr_ok  = 1'b0;
    n      = r;
    // inhibit sources
    inhibit = mon.shutdown_low_input | mon.charge_current_setting
            | mon.undervoltage_lockout | !r.en;
    // mode from input versus battery
    if (mon.vin_above_step_down) begin
      n.mode = MD_DOWN;
    end else if (mon.vin_below_step_up) begin
      n.mode = MD_UP;
    end else begin
      n.mode = MD_MIX;
    end
    // b timer length, doubled when both cycle types share a period
    bload  = (r.mode == MD_MIX) ? {r.btime[14:0], 1'b0} : r.btime;
    b_done = (r.tmr == 16'h0000);
    // switching state machine
    if (inhibit) begin
      n.state    = ST_D;
      n.phase_up = 1'b1;
    end else begin
      case (r.state)
        ST_A: begin
          if (r.mode == MD_DOWN && cmp.zero_crossing_comparator) begin
            n.state = ST_D;
          end else if (!cmp.current_mode_comparator &&
                       !cmp.lowest_error_clamp &&
                       !cmp.cycle_current_limit_comparator) begin
            n.state    = ST_B;
            n.phase_up = 1'b1;
          end
        end
        ST_B: begin
          if (b_done) begin
            if (r.mode == MD_UP || (r.mode == MD_MIX && r.phase_up)) begin
              n.state = ST_C;
            end else begin
              n.state = ST_A;
            end
          end
        end
        ST_C: begin
          if (cmp.cycle_current_limit_comparator) begin
            n.state = ST_B;
          end else if (cmp.lowest_error_clamp) begin
            if (cmp.minimum_current_comparator) begin
              n.state = ST_B;
            end
          end else if (cmp.current_mode_comparator) begin
            n.state = ST_B;
          end
          if (n.state == ST_B) begin
            n.phase_up = 1'b0;
          end
        end
        ST_D: begin
          if (r.mode == MD_UP ||
              (!cmp.lowest_error_clamp && !cmp.cycle_current_limit_comparator)) begin
            n.state    = ST_B;
            n.phase_up = 1'b1;
          end
        end
        default: begin
          n.state = ST_D;
        end
      endcase
    end
    // b timer
    if (n.state == ST_B && r.state != ST_B) begin
      n.tmr = bload;
    end else if (!b_done) begin
      n.tmr = r.tmr - 16'h0001;
    end
    // switch drives from the next state
    n.hs_on  = (n.state == ST_B) || (n.state == ST_C);
    n.ls_on  = (n.state == ST_C);
    n.clamp  = inhibit;
    n.reg_en = !mon.undervoltage_lockout;
    // regulation error source
    if (mon.charge_at_limit) begin
      n.err_sel = ER_CHG;
    end else if (mon.source_at_limit) begin
      n.err_sel = ER_SRC;
    end else begin
      n.err_sel = ER_VOLT;
    end
    n.sense_src = (r.mode == MD_UP);
    // axi write address and data capture
    if (s_axi_awvalid && r.awrdy) begin
      n.awv    = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wrdy) begin
      n.wv    = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    // register write once both halves are held
    if (r.awv && r.wv && !r.bvalid) begin
      cur   = 32'h0000_0000;
      wr_ok = 1'b1;
      case ({r.awaddr[11:2], 2'b00})
        `HBC_OFS_CTRL:   cur = {31'h0000_0000, r.en};
        `HBC_OFS_BTIME:  cur = {16'h0000, r.btime};
        `HBC_OFS_STATUS: cur = 32'h0000_0000;
        default:         wr_ok = 1'b0;
      endcase
      for (int i = 0; i < 4; i++) begin
        if (r.wstrb[i]) begin
          cur[i*8 +: 8] = r.wdata[i*8 +: 8];
        end
      end
      case ({r.awaddr[11:2], 2'b00})
        `HBC_OFS_CTRL:  n.en    = cur[`HBC_CTRL_EN_BIT];
        `HBC_OFS_BTIME: n.btime = cur[15:0];
        default:        n.en    = r.en;
      endcase
      n.awv    = 1'b0;
      n.wv     = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = wr_ok ? `HBC_RESP_OKAY : `HBC_RESP_SLVERR;
    end
    n.awrdy = !n.awv && !n.bvalid;
    n.wrdy  = !n.wv && !n.bvalid;
    // axi read
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r.arrdy) begin
      n.rresp = `HBC_RESP_OKAY;
      case ({s_axi_araddr[11:2], 2'b00})
        `HBC_OFS_CTRL:   rd = {31'h0000_0000, r.en};
        `HBC_OFS_BTIME:  rd = {16'h0000, r.btime};
        `HBC_OFS_STATUS: rd = {22'h00_0000, r.err_sel, r.clamp, r.ls_on,
                               r.hs_on, r.phase_up, r.mode, r.state};
        default:         n.rresp = `HBC_RESP_SLVERR;
      endcase
      n.rdata  = rd;
      n.rvalid = 1'b1;
    end
    n.arrdy = !n.rvalid;
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r           <= '0;
      r.state     <= ST_D;
      r.mode      <= MD_DOWN;
      r.phase_up  <= 1'b1;
      r.reg_en    <= 1'b1;
      r.clamp     <= 1'b1;
      r.err_sel   <= ER_VOLT;
      r.en        <= `HBC_CTRL_RST;
      r.btime     <= `HBC_BTIME_RST;
    end else begin
      r <= n;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign high_side_gate_drive = r.hs_on;
  assign low_side_gate_drive  = r.ls_on;
  assign comp_nodes_clamp     = r.clamp;
  assign internal_regulator   = r.reg_en;
  assign error_select         = r.err_sel;
  assign limit_sense_source   = r.sense_src;
  assign s_axi_awready        = r.awrdy;
  assign s_axi_wready         = r.wrdy;
  assign s_axi_bvalid         = r.bvalid;
  assign s_axi_bresp          = r.bresp;
  assign s_axi_arready        = r.arrdy;
  assign s_axi_rvalid         = r.rvalid;
  assign s_axi_rdata          = r.rdata;
  assign s_axi_rresp          = r.rresp;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  inhibit_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    inhibit |=> (!r.hs_on && !r.ls_on && r.clamp && r.state == ST_D))
    else $error("switching not stopped under inhibit");

  reg_alive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (inhibit && !mon.undervoltage_lockout) |=> r.reg_en)
    else $error("regulator dropped during inhibit");

  state_a_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == ST_A) |-> (!r.hs_on && !r.ls_on))
    else $error("drives wrong in state a");

  step_up_hs_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == ST_B || r.state == ST_C) |-> r.hs_on)
    else $error("high side off in b or c");

  one_switch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!inhibit && !$past(inhibit)) |->
      !($changed(r.hs_on) && $changed(r.ls_on)))
    else $error("both switches toggled together");

  limit_ends_c_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == ST_C && cmp.cycle_current_limit_comparator && !inhibit)
      |=> (r.state == ST_B && !r.ls_on))
    else $error("current limit did not end on-time");

  zero_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == ST_A && r.mode == MD_DOWN && cmp.zero_crossing_comparator && !inhibit)
      |=> (r.state == ST_D))
    else $error("zero crossing did not idle");

  no_dcm_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == ST_A && cmp.lowest_error_clamp) |=> (r.state != ST_B))
    else $error("on-time started in discontinuous mode");

  b_holds_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == ST_B && r.tmr != 16'h0000 && !inhibit) |=> (r.state == ST_B))
    else $error("state b left before timer end");

  b_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state != ST_B && n.state == ST_B && r.mode == MD_MIX)
      |=> (r.tmr == {$past(r.btime[14:0]), 1'b0}))
    else $error("combined b time not doubled");

  err_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!mon.charge_at_limit && !mon.source_at_limit) ##1
      (!mon.charge_at_limit && !mon.source_at_limit) |-> (r.err_sel == ER_VOLT))
    else $error("error source not battery voltage");

  step_down_ls_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.mode == MD_DOWN && r.state != ST_C) |=> !r.ls_on)
    else $error("low side on in step-down");

  down_b_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == ST_B && r.tmr == 16'h0000 && r.mode == MD_DOWN && !inhibit)
      |=> (r.state == ST_A && !r.hs_on))
    else $error("step-down b end did not start a");

  up_b_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == ST_B && r.tmr == 16'h0000 && r.mode == MD_UP && !inhibit)
      |=> (r.state == ST_C && r.ls_on))
    else $error("step-up b end did not start c");

  mix_b_up_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == ST_B && r.tmr == 16'h0000 && r.mode == MD_MIX && r.phase_up && !inhibit)
      |=> (r.state == ST_C))
    else $error("combined order b to c broken");

  mix_b_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == ST_B && r.tmr == 16'h0000 && r.mode == MD_MIX && !r.phase_up && !inhibit)
      |=> (r.state == ST_A))
    else $error("combined order b to a broken");

  c_peak_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == ST_C && !cmp.lowest_error_clamp && cmp.current_mode_comparator && !inhibit)
      |=> (r.state == ST_B && !r.ls_on))
    else $error("current threshold did not end c");

  a_valley_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == ST_A && !cmp.zero_crossing_comparator && !cmp.current_mode_comparator &&
     !cmp.lowest_error_clamp && !cmp.cycle_current_limit_comparator && !inhibit)
      |=> (r.state == ST_B && r.hs_on))
    else $error("valley did not end a");

  dcm_peak_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == ST_C && cmp.lowest_error_clamp && cmp.minimum_current_comparator && !inhibit)
      |=> (r.state == ST_B && !r.ls_on))
    else $error("minimum current did not end c");

  limit_no_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((r.state == ST_A || (r.state == ST_D && r.mode != MD_UP)) &&
      cmp.cycle_current_limit_comparator) |=> (r.state != ST_B))
    else $error("on-time started above current limit");

  up_sense_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.mode == MD_UP) |=> r.sense_src)
    else $error("step-up limit not on source sense");

  clamp_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !inhibit |=> !r.clamp)
    else $error("compensation clamped without inhibit");

  up_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == ST_D && r.mode == MD_UP && !inhibit) |=> (r.state == ST_B && r.hs_on))
    else $error("step-up did not leave idle");

  lockout_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mon.undervoltage_lockout |=> (!r.reg_en && r.state == ST_D))
    else $error("lockout did not shut down");

  rst_idle_a: assert property (@(posedge aclk)
    !aresetn |=> (r.state == ST_D && !r.hs_on && !r.ls_on && r.clamp))
    else $error("reset did not idle the bridge");

  b_load_plain_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state != ST_B && n.state == ST_B && r.mode != MD_MIX)
      |=> (r.tmr == $past(r.btime)))
    else $error("plain b time not loaded");

endmodule : hbc_ctrl
`default_nettype wire

// ---- rtl/hbc_defines.svh ----
// timing counts, register offsets, field positions and reset values
`ifndef HBC_DEFINES_SVH
`define HBC_DEFINES_SVH

// --------------------------------------------------------------------
// timebase
// --------------------------------------------------------------------
`define HBC_CLK_MHZ      250
`define HBC_BTIME_NS     1250
`define HBC_BTIME_CYC    ((`HBC_BTIME_NS * `HBC_CLK_MHZ + 999) / 1000)

// --------------------------------------------------------------------
// register offsets
// --------------------------------------------------------------------
`define HBC_OFS_CTRL     12'h000
`define HBC_OFS_BTIME    12'h004
`define HBC_OFS_STATUS   12'h008

// --------------------------------------------------------------------
// fields and reset values
// --------------------------------------------------------------------
`define HBC_CTRL_EN_BIT  0
`define HBC_CTRL_RST     1'h1
`define HBC_BTIME_RST    16'(`HBC_BTIME_CYC)
`define HBC_RESP_OKAY    2'h0
`define HBC_RESP_SLVERR  2'h2

`endif

// ---- rtl/hbc_pkg.sv ----
// types of the h-bridge switching-state controller
`default_nettype none
package hbc_pkg;

  // ------------------------------------------------------------------
  // switching states, converter modes and error sources
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_A,
    ST_B,
    ST_C,
    ST_D
  } hbc_state_e;

  typedef enum logic [1:0] {
    MD_DOWN,
    MD_UP,
    MD_MIX
  } hbc_mode_e;

  typedef enum logic [1:0] {
    ER_VOLT,
    ER_CHG,
    ER_SRC
  } hbc_err_e;

  // ------------------------------------------------------------------
  // input groups
  // ------------------------------------------------------------------
  typedef struct packed {
    logic minimum_current_comparator;
    logic lowest_error_clamp;
    logic current_mode_comparator;
    logic cycle_current_limit_comparator;
    logic zero_crossing_comparator;
  } hbc_cmp_s;

  typedef struct packed {
    logic shutdown_low_input;
    logic charge_current_setting;
    logic undervoltage_lockout;
    logic vin_above_step_down;
    logic vin_below_step_up;
    logic charge_at_limit;
    logic source_at_limit;
  } hbc_mon_s;

  // ------------------------------------------------------------------
  // whole module state
  // ------------------------------------------------------------------
  typedef struct packed {
    hbc_state_e  state;
    hbc_mode_e   mode;
    logic        phase_up;
    logic [15:0] tmr;
    logic        hs_on;
    logic        ls_on;
    logic        clamp;
    logic        reg_en;
    hbc_err_e    err_sel;
    logic        sense_src;
    logic        en;
    logic [15:0] btime;
    logic        awv;
    logic [11:0] awaddr;
    logic        wv;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awrdy;
    logic        wrdy;
    logic        arrdy;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } hbc_st_s;

endpackage : hbc_pkg
`default_nettype wire

// ---- tb/hbc_ctrl_tb.sv ----
// self-checking testbench of the switching-state controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) if ((g) !== (e)) begin $display("Error %s exp %h got %h", nm, e, g); fails++; end cmp_count++;
module hbc_ctrl_tb
  import hbc_pkg::*;
;
  typedef struct {logic up; logic dn; logic chg; logic src; hbc_err_e es; logic ss;} hbc_row_s;
  hbc_row_s rows [4] = '{'{0,1,0,0,ER_VOLT,0}, '{0,1,1,0,ER_CHG,0},
                         '{1,0,0,1,ER_SRC,1}, '{1,0,1,1,ER_CHG,1}};
  logic aclk = 1'b0, aresetn = 1'b0;
  hbc_mon_s mon = '0;
  hbc_cmp_s cmp;
  hbc_err_e es;
  logic hs, ls, clampo, rego, lss;
  logic vin_high = 1'b0, clamp_in = 1'b0;
  logic [7:0] thr = 8'h05, lim = 8'hff;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  int fails = 0, cmp_count = 0, n, k, hch, lch, hlo, lhi, both;

  always #2 aclk = ~aclk;

  hbc_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .cmp(cmp), .mon(mon),
    .high_side_gate_drive(hs), .low_side_gate_drive(ls), .comp_nodes_clamp(clampo),
    .internal_regulator(rego), .error_select(es), .limit_sense_source(lss),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  hbc_stage_model i_stage (.aclk(aclk), .hs(hs), .ls(ls), .vin_high(vin_high),
    .clamp_in(clamp_in), .thr(thr), .lim(lim), .cmp(cmp));

  task stop_test;
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task cyc(input int c);
    repeat (c) @(posedge aclk);
  endtask : cyc

  task wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awready === 1'b1 && !aw) begin aw = 1'b1; awvalid <= 1'b0; end
      if (wready === 1'b1 && !w) begin w = 1'b1; wvalid <= 1'b0; end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rdr

  // counts drive changes, high side low, low side high, double changes
  task watch(input int c);
    logic ph, pl;
    hch = 0; lch = 0; hlo = 0; lhi = 0; both = 0; ph = hs; pl = ls;
    repeat (c) begin
      @(posedge aclk);
      if (hs !== ph) hch++;
      if (ls !== pl) lch++;
      if (hs !== ph && ls !== pl) both++;
      if (hs !== 1'b1) hlo++;
      if (ls !== 1'b0) lhi++;
      ph = hs;
      pl = ls;
    end
  endtask : watch

  initial begin
    #200000;
    fails++;
    stop_test();
  end

  initial begin
    mon.shutdown_low_input <= 1'b1;
    cyc(3);
    `CHK("rst_drv", 2'b00, {hs, ls})
    `CHK("rst_clamp", 2'b11, {clampo, rego})
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(12'h000, rd, rs); `CHK("ctrl_rst", 32'h00000001, rd)
    rdr(12'h004, rd, rs); `CHK("btime_rst", 32'h00000139, rd)
    rdr(12'h00c, rd, rs); `CHK("bad_rresp", 2'h2, rs)
    `CHK("bad_rdata", 32'h00000000, rd)
    wr(12'h008, 32'hffffffff, rs); `CHK("ro_bresp", 2'h0, rs)
    wr(12'h004, 32'h0000000a, rs);
    for (k = 0; k < 4; k++) begin
      mon.vin_above_step_down <= rows[k].dn; mon.vin_below_step_up <= rows[k].up;
      mon.charge_at_limit <= rows[k].chg; mon.source_at_limit <= rows[k].src;
      cyc(4);
      `CHK("err_sel", rows[k].es, es)
      `CHK("sense_src", rows[k].ss, lss)
    end
    // step-down switching
    mon <= '{vin_above_step_down: 1'b1, default: 1'b0};
    vin_high <= 1'b1;
    n = 0;
    while (hs !== 1'b1 && n < 50) begin @(posedge aclk); n++; end
    k = 0;
    while (hs === 1'b1 && k < 100) begin @(posedge aclk); k++; end
    `CHK("b_len", 11, k)
    watch(150);
    `CHK("dn_ls_off", 0, lhi)
    `CHK("dn_cycle", 1'b1, (hch > 4))
    `CHK("dn_one_sw", 0, both)
    thr <= 8'h00; clamp_in <= 1'b1;
    cyc(100);
    rdr(12'h008, rd, rs); `CHK("zero_idle", 2'h3, rd[1:0])
    `CHK("clamp_idle", 1'b0, hs)
    clamp_in <= 1'b0; lim <= 8'h00;
    cyc(30); `CHK("lim_block", 1'b0, hs)
    lim <= 8'hff;
    // combined mode
    mon.vin_above_step_down <= 1'b0; thr <= 8'h08;
    cyc(20); watch(300);
    `CHK("mix_hs", 1'b1, (hch > 1))
    `CHK("mix_ls", 1'b1, (lch > 1))
    `CHK("mix_one_sw", 0, both)
    // step-up switching
    mon.vin_below_step_up <= 1'b1; vin_high <= 1'b0;
    cyc(60); watch(200);
    `CHK("up_hs_on", 0, hlo)
    `CHK("up_ls_tgl", 1'b1, (lch > 2))
    `CHK("up_one_sw", 0, both)
    // discontinuous step-up: minimum current ends c, high side stays on
    clamp_in <= 1'b1;
    watch(60);
    `CHK("dcm_hs_on", 0, hlo)
    `CHK("dcm_ls_tgl", 1'b1, (lch > 2))
    clamp_in <= 1'b0;
    // every inhibit source
    for (k = 0; k < 4; k++) begin
      if (k == 0) mon.shutdown_low_input <= 1'b1;
      if (k == 1) mon.charge_current_setting <= 1'b1;
      if (k == 2) mon.undervoltage_lockout <= 1'b1;
      if (k == 3) wr(12'h000, 32'h00000000, rs);
      cyc(3);
      `CHK("inh_drv", 3'b001, {hs, ls, clampo})
      `CHK("inh_reg", (k != 2), rego)
      rdr(12'h008, rd, rs); `CHK("inh_rd", 2'h0, rs)
      mon <= '{vin_below_step_up: 1'b1, default: 1'b0};
      if (k == 3) wr(12'h000, 32'h00000001, rs);
      cyc(20); `CHK("inh_exit", 1'b1, hs)
    end
    aresetn <= 1'b0;
    cyc(2);
    `CHK("rst2_drv", 3'b001, {hs, ls, clampo})
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(12'h004, rd, rs); `CHK("btime_rst2", 32'h00000139, rd)
    stop_test();
  end
endmodule : hbc_ctrl_tb
`default_nettype wire

// ---- tb/hbc_stage_model.sv ----
// power stage model: inductor current ramp and comparator outputs
`timescale 1ns/100ps
`default_nettype none
module hbc_stage_model
  import hbc_pkg::*;
(
  // clock
  input  wire logic       aclk,
  // switch drives and stage settings
  input  wire logic       hs,
  input  wire logic       ls,
  input  wire logic       vin_high,
  input  wire logic       clamp_in,
  input  wire logic [7:0] thr,
  input  wire logic [7:0] lim,
  // comparator outputs
  output var  hbc_cmp_s   cmp
);
  logic [7:0] cur = 8'h00;
  // low side on ramps fast, high side alone ramps by vin versus vbatt
  always @(posedge aclk) begin
    if (ls === 1'b1) cur <= cur + 8'h02;
    else if (hs === 1'b1 && vin_high) cur <= cur + 8'h01;
    else if (cur != 8'h00) cur <= cur - 8'h01;
  end
  always_comb begin
    cmp.minimum_current_comparator     = (cur > 8'h04);
    cmp.lowest_error_clamp             = clamp_in;
    cmp.current_mode_comparator        = (cur > thr);
    cmp.cycle_current_limit_comparator = (cur >= lim);
    cmp.zero_crossing_comparator       = (cur == 8'h00);
  end
endmodule : hbc_stage_model
`default_nettype wire
